// *** hdl/rx_label_filter_irq_queue.sv ***
`timescale 1ns/1ns
module rx_label_filter_irq_queue
  import rx_filt_pkg::*;
#(
  parameter int CHAN_W      = 5,
  parameter int TBL_AW      = CHAN_W + COMBO_W,
  parameter int CLEAR_COUNT = 2**(CHAN_W + COMBO_W)
) (
  input  wire logic              mclk,
  input  wire logic              rstn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              rx_valid,
  input  wire logic [CHAN_W-1:0] rx_chan,
  input  wire logic [31:0]       rx_word,
  output logic                   rx_ready,
  output logic                   circ_valid,
  output logic                   circ_merged,
  output logic [CHAN_W-1:0]      circ_chan,
  output logic [31:0]            circ_word,
  output logic                   snap_valid,
  output logic [CHAN_W-1:0]      snap_chan,
  output logic [31:0]            snap_word,
  output logic                   irq
);

  localparam int NCH = 2**CHAN_W;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  tbl_state_t            state_r;
  logic [TBL_AW-1:0]     clr_idx_r;
  logic                  gate_r;
  logic [1:0]            status_r;
  logic [1:0]            mask_r;
  logic [QUEUE_AW-1:0]   q_idx_r;
  logic [TBL_AW-1:0]     f_addr_r;
  logic [NCH-1:0]        merge_r;
  logic                  test_pend_r;
  logic                  lk_valid_r;
  logic [CHAN_W-1:0]     lk_chan_r;
  logic [31:0]           lk_word_r;
  logic [FLAG_W-1:0]     lk_flags;
  logic [FLAG_W-1:0]     hr_flags;
  logic [31:0]           q_rdata;
  logic [QUEUE_AW-1:0]   q_head;
  logic                  acc_r;
  logic                  apb_wr;
  logic                  apb_rd_cap;
  logic                  addr_ok;
  logic [31:0]           rd_mux;
  logic                  tbl_wr;
  logic [TBL_AW-1:0]     tbl_wr_addr;
  logic [FLAG_W-1:0]     tbl_wr_data;
  logic                  rx_take;
  logic                  rx_event;
  logic                  test_take;
  logic                  q_push;
  logic [31:0]           q_entry;

  function automatic logic [TBL_AW-1:0] tbl_index(input logic [CHAN_W-1:0] ch, input logic [31:0] w);
    tbl_index = {ch, w[POS_SSM_HI:POS_SSM_LO], w[POS_SD_HI:POS_SD_LO], w[POS_LABEL_HI:POS_LABEL_LO]};
  endfunction

  function automatic logic w1_hit(input logic [7:0] ofs);
    w1_hit = apb_wr && (paddr == ofs);
  endfunction

  // ----------------------------------------
  // apb slave: one wait state, then pready
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      acc_r <= 1'b0;
    end else begin
      acc_r <= psel && penable && !acc_r;
    end
  end

  // the wait state lets synchronous table and queue reads settle into prdata
  assign pready     = psel && penable && acc_r;
  assign apb_wr     = pready && pwrite && addr_ok;
  assign apb_rd_cap = psel && penable && !acc_r;

  always_comb begin
    addr_ok = 1'b1;
    rd_mux  = 32'h0000_0000;
    case (paddr)
      OFS_GLOBAL_EN:  rd_mux[POS_IRQ_GATE] = gate_r;
      OFS_IRQ_STATUS: rd_mux[1:0] = status_r;
      OFS_IRQ_MASK:   rd_mux[1:0] = mask_r;
      OFS_QUEUE:      rd_mux[QUEUE_AW-1:0] = q_head;
      OFS_QUEUE_IDX:  rd_mux[QUEUE_AW-1:0] = q_idx_r;
      OFS_QUEUE_DATA: rd_mux = q_rdata;
      OFS_FILT_ADDR:  rd_mux[TBL_AW-1:0] = f_addr_r;
      OFS_FILT_DATA: begin
        rd_mux[POS_SW_CIRC]  = hr_flags[FL_CIRC];
        rd_mux[POS_SW_SNAP]  = hr_flags[FL_SNAP];
        rd_mux[POS_SW_EVENT] = hr_flags[FL_EVENT];
      end
      OFS_MERGE_MODE: rd_mux[NCH-1:0] = merge_r;
      OFS_STATUS:     rd_mux[0] = (state_r == ST_CLEAR);
      default:        addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (apb_rd_cap) begin
      prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr <= !addr_ok;
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      gate_r   <= 1'b0;
      mask_r   <= 2'h0;
      q_idx_r  <= '0;
      f_addr_r <= '0;
      merge_r  <= '0;
    end else begin
      if (w1_hit(OFS_GLOBAL_EN)) begin
        gate_r <= pwdata[POS_IRQ_GATE];
      end
      if (w1_hit(OFS_IRQ_MASK)) begin
        mask_r <= pwdata[1:0];
      end
      if (w1_hit(OFS_QUEUE_IDX)) begin
        q_idx_r <= pwdata[QUEUE_AW-1:0];
      end
      if (w1_hit(OFS_FILT_ADDR)) begin
        f_addr_r <= pwdata[TBL_AW-1:0];
      end
      if (w1_hit(OFS_MERGE_MODE)) begin
        merge_r <= pwdata[NCH-1:0];
      end
    end
  end

  // ----------------------------------------
  // table clear sweep after reset
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_r   <= ST_CLEAR;
      clr_idx_r <= '0;
    end else begin
      case (state_r)
        ST_CLEAR: begin
          clr_idx_r <= clr_idx_r + TBL_AW'(1);
          if (clr_idx_r == TBL_AW'(CLEAR_COUNT - 1)) begin
            state_r <= ST_RUN;
          end
        end
        ST_RUN:   state_r <= ST_RUN;
        default:  state_r <= ST_CLEAR;
      endcase
    end
  end

  // host table writes are ignored while the sweep runs
  always_comb begin
    if (state_r == ST_CLEAR) begin
      tbl_wr      = 1'b1;
      tbl_wr_addr = clr_idx_r;
      tbl_wr_data = FLAGS_CLEAR;
    end else begin
      tbl_wr      = w1_hit(OFS_FILT_DATA);
      tbl_wr_addr = f_addr_r;
      tbl_wr_data = {pwdata[POS_SW_EVENT], pwdata[POS_SW_SNAP], pwdata[POS_SW_CIRC]};
    end
  end

  label_filter_table #(
    .AW (TBL_AW)
  ) u_table (
    .mclk    (mclk),
    .wr_en   (tbl_wr),
    .wr_addr (tbl_wr_addr),
    .wr_data (tbl_wr_data),
    .lk_addr (tbl_index(rx_chan, rx_word)),
    .lk_data (lk_flags),
    .hr_addr (f_addr_r),
    .hr_data (hr_flags)
  );

  // ----------------------------------------
  // receive path: lookup, then commit
  // ----------------------------------------
  assign rx_ready = (state_r == ST_RUN);
  assign rx_take  = rx_valid && rx_ready;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      lk_valid_r <= 1'b0;
      lk_chan_r  <= '0;
      lk_word_r  <= 32'h0000_0000;
    end else begin
      lk_valid_r <= rx_take;
      if (rx_take) begin
        lk_chan_r <= rx_chan;
        lk_word_r <= rx_word;
      end
    end
  end

  // every word is judged on its own flags, no state carried between words
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      circ_valid  <= 1'b0;
      circ_merged <= 1'b0;
      circ_chan   <= '0;
      circ_word   <= 32'h0000_0000;
      snap_valid  <= 1'b0;
      snap_chan   <= '0;
      snap_word   <= 32'h0000_0000;
    end else begin
      circ_valid  <= lk_valid_r && !lk_flags[FL_CIRC];
      circ_merged <= merge_r[lk_chan_r];
      circ_chan   <= lk_chan_r;
      circ_word   <= lk_word_r;
      snap_valid  <= lk_valid_r && !lk_flags[FL_SNAP];
      snap_chan   <= lk_chan_r;
      snap_word   <= lk_word_r;
    end
  end

  // ----------------------------------------
  // interrupt queue
  // ----------------------------------------
  assign rx_event  = lk_valid_r && lk_flags[FL_EVENT];
  assign test_take = test_pend_r && !rx_event;
  assign q_push    = rx_event || test_take;
  assign q_entry   = rx_event ? (RX_EVENT_BASE + 32'(lk_chan_r)) : TEST_ENTRY;

  // receive events take the slot; a test write waits for a cycle without a receive event rather than being lost
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      test_pend_r <= 1'b0;
    end else begin
      test_pend_r <= w1_hit(OFS_QUEUE) || (test_pend_r && !test_take);
    end
  end

  irq_event_queue #(
    .DEPTH (QUEUE_DEPTH),
    .AW    (QUEUE_AW)
  ) u_queue (
    .mclk    (mclk),
    .rstn    (rstn),
    .push    (q_push),
    .entry   (q_entry),
    .rd_idx  (q_idx_r),
    .rd_data (q_rdata),
    .head_r  (q_head)
  );

  // ----------------------------------------
  // sticky status, mask and gate
  // ----------------------------------------
  // set beats a write-one-to-clear in the same cycle
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      status_r <= 2'h0;
    end else begin
      status_r[POS_EV_RX]   <= rx_event ||
                               (status_r[POS_EV_RX] && !(w1_hit(OFS_IRQ_STATUS) && pwdata[POS_EV_RX]));
      status_r[POS_EV_TEST] <= test_take ||
                               (status_r[POS_EV_TEST] && !(w1_hit(OFS_IRQ_STATUS) && pwdata[POS_EV_TEST]));
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= gate_r && |(status_r & mask_r);
    end
  end

endmodule

// *** hdl/rx_filt_pkg.sv ***
package rx_filt_pkg;

  // ----------------------------------------
  // apb register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_GLOBAL_EN   = 8'h00;
  localparam logic [7:0] OFS_IRQ_STATUS  = 8'h04;
  localparam logic [7:0] OFS_IRQ_MASK    = 8'h08;
  localparam logic [7:0] OFS_QUEUE       = 8'h0c;
  localparam logic [7:0] OFS_QUEUE_IDX   = 8'h10;
  localparam logic [7:0] OFS_QUEUE_DATA  = 8'h14;
  localparam logic [7:0] OFS_FILT_ADDR   = 8'h18;
  localparam logic [7:0] OFS_FILT_DATA   = 8'h1c;
  localparam logic [7:0] OFS_MERGE_MODE  = 8'h20;
  localparam logic [7:0] OFS_STATUS      = 8'h24;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int POS_IRQ_GATE     = 0;
  localparam int POS_EV_RX        = 0;
  localparam int POS_EV_TEST      = 1;
  localparam int POS_SW_CIRC      = 4;
  localparam int POS_SW_SNAP      = 5;
  localparam int POS_SW_EVENT     = 6;
  localparam int POS_SSM_HI       = 30;
  localparam int POS_SSM_LO       = 28;
  localparam int POS_SD_HI        = 9;
  localparam int POS_SD_LO        = 8;
  localparam int POS_LABEL_HI     = 7;
  localparam int POS_LABEL_LO     = 0;
  localparam int FL_CIRC          = 0;
  localparam int FL_SNAP          = 1;
  localparam int FL_EVENT         = 2;

  // ----------------------------------------
  // widths, depths, codes, reset values
  // ----------------------------------------
  localparam int COMBO_W          = 13;
  localparam int FLAG_W           = 3;
  localparam int QUEUE_DEPTH      = 2048;
  localparam int QUEUE_AW         = 11;
  localparam logic [31:0] RX_EVENT_BASE = 32'h0000_0040;
  localparam logic [31:0] TEST_ENTRY    = 32'h0000_00ff;
  localparam logic [QUEUE_AW-1:0] HEAD_RESET = 11'h7ff;
  localparam logic [FLAG_W-1:0]   FLAGS_CLEAR = 3'h0;

  typedef enum logic [1:0] {
    ST_CLEAR = 2'b00,
    ST_RUN   = 2'b01
  } tbl_state_t;

endpackage

// *** hdl/label_filter_table.sv ***
`timescale 1ns/1ns
module label_filter_table
  import rx_filt_pkg::*;
#(
  parameter int AW = 18
) (
  input  wire logic              mclk,
  input  wire logic              wr_en,
  input  wire logic [AW-1:0]     wr_addr,
  input  wire logic [FLAG_W-1:0] wr_data,
  input  wire logic [AW-1:0]     lk_addr,
  output logic      [FLAG_W-1:0] lk_data,
  input  wire logic [AW-1:0]     hr_addr,
  output logic      [FLAG_W-1:0] hr_data
);

  // per-channel sections: index is {channel, sign/status, source/dest, label}
  logic [FLAG_W-1:0] mem [0:(2**AW)-1];

  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge mclk) begin
    lk_data <= mem[lk_addr];
  end

  always_ff @(posedge mclk) begin
    hr_data <= mem[hr_addr];
  end

endmodule

// *** hdl/irq_event_queue.sv ***
`timescale 1ns/1ns
module irq_event_queue
  import rx_filt_pkg::*;
#(
  parameter int DEPTH = QUEUE_DEPTH,
  parameter int AW    = QUEUE_AW
) (
  input  wire logic          mclk,
  input  wire logic          rstn,
  input  wire logic          push,
  input  wire logic [31:0]   entry,
  input  wire logic [AW-1:0] rd_idx,
  output logic      [31:0]   rd_data,
  output logic      [AW-1:0] head_r
);

  logic [31:0]   mem [0:DEPTH-1];
  logic [AW-1:0] head_nxt;

  // power-of-two depth, so the increment wraps on its own
  assign head_nxt = head_r + AW'(1);

  // entry and pointer move on the same edge; a host read never sees one without the other
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      head_r <= HEAD_RESET;
    end else if (push) begin
      head_r <= head_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[head_nxt] <= entry;
    end
  end

  always_ff @(posedge mclk) begin
    rd_data <= mem[rd_idx];
  end

endmodule

// *** sim/rx_filt_props.sv ***
`timescale 1ns/1ns
module rx_filt_props
  import rx_filt_pkg::*;
#(
  parameter int CHAN_W = 5
) (
  input wire logic              mclk,
  input wire logic              rstn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [7:0]        paddr,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              rx_valid,
  input wire logic [CHAN_W-1:0] rx_chan,
  input wire logic [31:0]       rx_word,
  input wire logic              rx_ready,
  input wire logic              circ_valid,
  input wire logic [CHAN_W-1:0] circ_chan,
  input wire logic [31:0]       circ_word,
  input wire logic              snap_valid,
  input wire logic [CHAN_W-1:0] snap_chan,
  input wire logic [31:0]       snap_word,
  input wire logic              irq
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  logic take;
  logic wdone;
  assign take  = rx_valid && rx_ready;
  assign wdone = pwrite && pready;
  property p_rdy_qual; pready |-> psel && penable; endproperty
  a_rdy_qual: assert property (p_rdy_qual) else $error("pready outside access");
  property p_one_wait; psel && $rose(penable) |-> !pready ##1 pready; endproperty
  a_one_wait: assert property (p_one_wait) else $error("apb wait state wrong");
  property p_err_zero; pready && pslverr |-> prdata == 32'h0; endproperty
  a_err_zero: assert property (p_err_zero) else $error("error read not zero");
  property p_unmapped; pready && paddr > 8'h24 |-> pslverr; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
  property p_circ_lat;
    circ_valid |-> $past(take, 2) && circ_chan == $past(rx_chan, 2) && circ_word == $past(rx_word, 2);
  endproperty
  a_circ_lat: assert property (p_circ_lat) else $error("circ store mismatch");
  property p_snap_lat;
    snap_valid |-> $past(take, 2) && snap_chan == $past(rx_chan, 2) && snap_word == $past(rx_word, 2);
  endproperty
  a_snap_lat: assert property (p_snap_lat) else $error("snap store mismatch");
  property p_ready_keep; rx_ready |=> rx_ready; endproperty
  a_ready_keep: assert property (p_ready_keep) else $error("rx_ready dropped");
  property p_irq_cause;
    $rose(irq) |-> $past(wdone) || $past(wdone, 2) || $past(wdone, 3) || $past(take, 2) || $past(take, 3);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");
  cover property (circ_valid && snap_valid);
  cover property (pready && pslverr);
  cover property ($rose(irq));
endmodule
bind rx_label_filter_irq_queue rx_filt_props #(.CHAN_W(CHAN_W)) i_props (.mclk(mclk), .rstn(rstn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .rx_valid(rx_valid), .rx_chan(rx_chan), .rx_word(rx_word), .rx_ready(rx_ready),
  .circ_valid(circ_valid), .circ_chan(circ_chan), .circ_word(circ_word), .snap_valid(snap_valid),
  .snap_chan(snap_chan), .snap_word(snap_word), .irq(irq));

// *** sim/rx_chan_model.sv ***
`timescale 1ns/1ns
module rx_chan_model #(
  parameter int CHAN_W = 1
) (
  input  wire logic              mclk,
  input  wire logic              rstn,
  input  wire logic              rx_ready,
  output logic                   rx_valid,
  output logic      [CHAN_W-1:0] rx_chan,
  output logic      [31:0]       rx_word
);
  // ----------------------------------------
  // word source
  // ----------------------------------------
  logic [CHAN_W+31:0] q[$];
  task put(input logic [CHAN_W-1:0] c, input logic [31:0] w);
    q.push_back({c, w});
  endtask
  // idle word toggles so a stale value never looks valid
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rx_valid <= 1'b0;
      rx_chan  <= '0;
      rx_word  <= 32'h0;
    end else if (!rx_valid || rx_ready) begin
      if (q.size() > 0) begin
        {rx_chan, rx_word} <= q.pop_front();
        rx_valid <= 1'b1;
      end else begin
        rx_valid <= 1'b0;
        rx_word  <= ~rx_word;
      end
    end
  end
endmodule

// *** sim/tb.sv ***
`timescale 1ns/1ns
module tb
  import rx_filt_pkg::*;
;
  // ----------------------------------------
  // bench signals
  // ----------------------------------------
  logic        mclk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, rx_word, circ_word, snap_word, rd, clast, w;
  logic        pready, pslverr, rx_valid, rx_chan, rx_ready, circ_valid, circ_merged, circ_chan;
  logic        snap_valid, snap_chan, irq, err, cmerg;
  logic [10:0] hd;
  int          num_errors = 0, total_checks = 0, cyc = 0, ccnt = 0, scnt = 0;
  always #25 mclk = ~mclk;
  // small table keeps the clear sweep short
  rx_label_filter_irq_queue #(.CHAN_W(1), .CLEAR_COUNT(16384)) i_dut (.mclk(mclk), .rstn(rstn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid), .rx_chan(rx_chan), .rx_word(rx_word),
    .rx_ready(rx_ready), .circ_valid(circ_valid), .circ_merged(circ_merged), .circ_chan(circ_chan),
    .circ_word(circ_word), .snap_valid(snap_valid), .snap_chan(snap_chan), .snap_word(snap_word),
    .irq(irq));
  rx_chan_model #(.CHAN_W(1)) i_rx (.mclk(mclk), .rstn(rstn), .rx_ready(rx_ready),
    .rx_valid(rx_valid), .rx_chan(rx_chan), .rx_word(rx_word));
  always @(posedge mclk) begin
    cyc++;
    if (circ_valid) begin
      ccnt++;
      clast = circ_word;
      cmerg = circ_merged;
    end
    if (snap_valid) scnt++;
    // ceiling: the 16384-cycle clear sweep plus over 23000 cycles for bus transfers
    if (cyc > 40000) begin
      num_errors++;
      close_out();
    end
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task close_out;
    if (num_errors == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task apb(input logic wr_n, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1; penable <= 0; pwrite <= wr_n; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 32'h0);
    chk(n, e, rd);
  endtask
  task filt(input logic c, input logic [31:0] x, input logic [2:0] f);
    apb(1, OFS_FILT_ADDR, {18'h0, c, x[30:28], x[9:8], x[7:0]});
    apb(1, OFS_FILT_DATA, {25'h0, f, 4'h0});
  endtask
  task xfer(input logic c, input logic [31:0] x, input logic [2:0] f);
    int c0, s0;
    c0 = ccnt;
    s0 = scnt;
    i_rx.put(c, x);
    repeat (6) @(posedge mclk);
    chk("circ", {31'h0, !f[0]}, 32'(ccnt - c0));
    chk("snap", {31'h0, !f[1]}, 32'(scnt - s0));
    if (!f[0]) chk("cword", x, clast);
    if (f[2]) hd++;
    rdc("head", OFS_QUEUE, {21'h0, hd});
    if (f[2]) begin
      apb(1, OFS_QUEUE_IDX, {21'h0, hd});
      rdc("entry", OFS_QUEUE_DATA, RX_EVENT_BASE + c);
    end
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge mclk);
    rstn <= 1;
    hd = HEAD_RESET;
    rdc("busy", OFS_STATUS, 32'h1);
    rdc("gate", OFS_GLOBAL_EN, 32'h0);
    rdc("head", OFS_QUEUE, {21'h0, hd});
    rdc("bad", 8'h40, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    while (rx_ready !== 1'b1) @(posedge mclk);
    rdc("busy", OFS_STATUS, 32'h0);
    apb(1, OFS_IRQ_MASK, 32'h1);
    for (int f = 0; f < 8; f++) begin
      w = 32'h1000_0100 | f;
      apb(1, OFS_FILT_ADDR, {18'h0, w[0], w[30:28], w[9:8], w[7:0]});
      rdc("clr", OFS_FILT_DATA, 32'h0);
      apb(1, OFS_FILT_DATA, 32'(f) << 4);
      xfer(w[0], w, 3'(f));
    end
    chk("irq_off", 32'h0, {31'h0, irq});
    apb(1, OFS_GLOBAL_EN, 32'h1);
    repeat (2) @(posedge mclk);
    chk("irq_on", 32'h1, {31'h0, irq});
    apb(1, OFS_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge mclk);
    chk("irq_clr", 32'h0, {31'h0, irq});
    w = 32'h1000_0107;
    xfer(1, w, 3'h7);
    xfer(1, w ^ 32'h8fff_fc00, 3'h7);
    xfer(1, w ^ 32'h1000_0000, 3'h0);
    xfer(0, w, 3'h0);
    filt(1, w, 3'h0);
    xfer(1, w, 3'h0);
    apb(1, OFS_MERGE_MODE, 32'h2);
    filt(1, w, 3'h1);
    xfer(1, w, 3'h1);
    filt(1, w, 3'h0);
    xfer(1, w, 3'h0);
    chk("merged", 32'h1, {31'h0, cmerg});
    filt(1, w, 3'h4);
    i_rx.put(1, w);
    i_rx.put(1, w);
    repeat (6) @(posedge mclk);
    hd = hd + 11'h2;
    rdc("head2", OFS_QUEUE, {21'h0, hd});
    apb(1, OFS_IRQ_STATUS, 32'h3);
    apb(1, OFS_QUEUE, 32'h5a);
    hd++;
    repeat (2) @(posedge mclk);
    rdc("thead", OFS_QUEUE, {21'h0, hd});
    apb(1, OFS_QUEUE_IDX, {21'h0, hd});
    rdc("tentry", OFS_QUEUE_DATA, TEST_ENTRY);
    rdc("tstat", OFS_IRQ_STATUS, 32'h2);
    close_out();
  end
endmodule
